// ===== hdl/security_lock_pkg.sv
// constants and types shared by the drive security lock design
package security_lock_pkg;

  // stored password width, one entry per credential
  localparam int          PW_W          = 256;

  // security command opcodes
  localparam logic [7:0]  OP_SET_PW     = 8'hf1;
  localparam logic [7:0]  OP_UNLOCK     = 8'hf2;
  localparam logic [7:0]  OP_ERASE_PREP = 8'hf3;
  localparam logic [7:0]  OP_ERASE_UNIT = 8'hf4;
  localparam logic [7:0]  OP_FREEZE     = 8'hf5;
  localparam logic [7:0]  OP_DISABLE_PW = 8'hf6;

  // master password revision code range and shipping value
  localparam logic [15:0] REV_MIN       = 16'h0001;
  localparam logic [15:0] REV_MAX       = 16'hfffe;
  localparam logic [15:0] REV_SHIP      = 16'hfffe;

  // unlock mismatch attempt limit
  localparam logic [2:0]  ATTEMPT_LIMIT = 3'h5;
  localparam logic [2:0]  CNT_RESET     = 3'h0;

  // password store entries
  localparam logic        ADDR_USER     = 1'b0;
  localparam logic        ADDR_MASTER   = 1'b1;

  typedef enum logic [2:0] {
    SEC_LOCKED   = 3'b001,
    SEC_UNLOCKED = 3'b010,
    SEC_FROZEN   = 3'b100
  } sec_state_e;

  typedef enum logic [2:0] {
    CT_INIT = 3'b001,
    CT_IDLE = 3'b010,
    CT_EXEC = 3'b100
  } ctl_state_e;

  // values after power-on reset
  localparam sec_state_e  SEC_RESET     = SEC_UNLOCKED;
  localparam ctl_state_e  CT_RESET      = CT_INIT;

endpackage

// ===== hdl/pw_store_if.sv
// carrier between the lock controller and its password store
`timescale 1ns/1ps
`default_nettype none
interface pw_store_if;
  logic                              rdEn;
  logic                              rdAddr;
  logic [security_lock_pkg::PW_W-1:0] rdData;
  logic                              wrEn;
  logic                              wrAddr;
  logic [security_lock_pkg::PW_W-1:0] wrData;

  modport ctrl (output rdEn, output rdAddr, input rdData,
                output wrEn, output wrAddr, output wrData);
  modport mem  (input rdEn, input rdAddr, output rdData,
                input wrEn, input wrAddr, input wrData);
endinterface
`default_nettype wire

// ===== hdl/password_store.sv
// two-entry password memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module password_store
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  pw_store_if.mem   port
);
  // array has no reset: it stands in for non-volatile storage
  logic [security_lock_pkg::PW_W-1:0] mem [2];
  logic [security_lock_pkg::PW_W-1:0] rdData_r;
  logic [security_lock_pkg::PW_W-1:0] rdData_nxt;

  // read data selection
  always_comb
  begin
    rdData_nxt = rdData_r;
    if (port.rdEn)
    begin
      rdData_nxt = mem[port.rdAddr];
    end
  end

  // array write, kept out of reset on purpose
  always_ff @(posedge clk_sys)
  begin
    if (port.wrEn)
    begin
      mem[port.wrAddr] <= port.wrData;
    end
  end

  // read register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData_r <= '0;
    end
    else
    begin
      rdData_r <= rdData_nxt;
    end
  end

  assign port.rdData = rdData_r;

  // entries written since power-on; unwritten ones hold no defined value
  logic [1:0] filled_r;
  logic [1:0] filled_nxt;

  // fill marks
  always_comb
  begin
    filled_nxt = filled_r;
    if (port.wrEn)
    begin
      filled_nxt[port.wrAddr] = 1'b1;
    end
  end

  // fill mark registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filled_r <= 2'h0;
    end
    else
    begin
      filled_r <= filled_nxt;
    end
  end

  // read data follow the addressed entry one cycle later
  read_lat_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    port.rdEn && !port.wrEn && filled_r[port.rdAddr]
    |=> rdData_r == $past(mem[port.rdAddr]))
    else $error("password read data wrong");
endmodule // password_store
`default_nettype wire

// ===== hdl/attempt_counter.sv
// unlock mismatch counter with sticky expiry flag
`timescale 1ns/1ps
`default_nettype none
module attempt_counter
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic inc,
  input  wire logic clr,
  output logic      expired
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       exp_r;
  logic       exp_nxt;

  // R13 count and attempt_limit_expired_flag
  // a mismatch in the clearing cycle wins below the limit and counts on from the old value
  always_comb
  begin
    cnt_nxt = cnt_r;
    exp_nxt = exp_r;
    if (clr)
    begin
      cnt_nxt = security_lock_pkg::CNT_RESET;
      exp_nxt = 1'b0;
    end
    if (inc && cnt_r != security_lock_pkg::ATTEMPT_LIMIT)
    begin
      cnt_nxt = cnt_r + 3'h1;
      exp_nxt = (cnt_r + 3'h1) == security_lock_pkg::ATTEMPT_LIMIT;
    end
  end

  // counter registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= security_lock_pkg::CNT_RESET;
      exp_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired = exp_r;

  // fifth mismatch raises the flag
  limit_hit_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    inc && cnt_r == 3'h4 |=> exp_r && cnt_r == 3'h5)
    else $error("expiry flag not set at limit");
endmodule // attempt_counter
`default_nettype wire

// ===== hdl/drive_security_lock_fsm.sv
// drive security lock state machine and command gate
//
// Overview of operation
// R1: decode security opcodes F1h through F6h
// R2: locked device aborts media access commands
// R3: unlocked state entered by power-up or unlock
// R4: frozen refuses password and lock changes
// R5: frozen holds until power is removed
// R6: high level accepts master password unlock
// R7: maximum level: master only via erase
// R8: master password never enables locking
// R9: master revision code word, 0001h..FFFEh
// R10: revision code FFFEh until master replaced
// R11: user password locks at next reset
// R12: host sets master before enabling lock
// R13: five mismatches attempt_limit_expired_flag unlock and erase
// R14: command gated per security state
// R15: mismatched password aborts, state unchanged
`timescale 1ns/1ps
`default_nettype none
module drive_security_lock_fsm
(
  input  wire logic                              clk_sys,
  input  wire logic                              rst_n,
  input  wire logic                              hardRst,
  input  wire logic                              nvUserPwdSet,
  input  wire logic                              nvLevelMax,
  input  wire logic [15:0]                       nvMasterRev,
  input  wire logic                              cmdValid,
  input  wire logic [7:0]                        cmdOpcode,
  input  wire logic                              cmdIsMedia,
  input  wire logic                              cmdUseMaster,
  input  wire logic                              cmdLevelMax,
  input  wire logic [15:0]                       cmdRevCode,
  input  wire logic [security_lock_pkg::PW_W-1:0] cmdPassword,
  output logic                                   cmdReady,
  output logic                                   rspDone,
  output logic                                   rspAbort,
  output logic                                   eraseStart,
  output logic                                   secLocked,
  output logic                                   secUnlocked,
  output logic                                   secFrozen,
  output logic                                   lockEnabled,
  output logic                                   levelMax,
  output logic                                   attemptLimitExpiredFlag,
  output logic [15:0]                            masterRevCode
);
  security_lock_pkg::ctl_state_e       ctl_r;
  security_lock_pkg::ctl_state_e       ctl_nxt;
  security_lock_pkg::sec_state_e       sec_r;
  security_lock_pkg::sec_state_e       sec_nxt;
  logic [7:0]                          op_r;
  logic [7:0]                          op_nxt;
  logic                                media_r;
  logic                                media_nxt;
  logic                                useMaster_r;
  logic                                useMaster_nxt;
  logic                                cmdLvl_r;
  logic                                cmdLvl_nxt;
  logic [15:0]                         rev_r;
  logic [15:0]                         rev_nxt;
  logic [security_lock_pkg::PW_W-1:0]  pw_r;
  logic [security_lock_pkg::PW_W-1:0]  pw_nxt;
  logic                                ready_r;
  logic                                ready_nxt;
  logic                                done_r;
  logic                                done_nxt;
  logic                                abort_r;
  logic                                abort_nxt;
  logic                                erase_r;
  logic                                erase_nxt;
  logic                                lockEn_r;
  logic                                lockEn_nxt;
  logic                                lvlMax_r;
  logic                                lvlMax_nxt;
  logic                                prepared_r;
  logic                                prepared_nxt;
  logic [15:0]                         mrev_r;
  logic [15:0]                         mrev_nxt;
  logic                                take;
  logic                                pwMatch;
  logic                                cntInc;
  logic                                expired;
  logic                                ok;

  pw_store_if pwBus ();

  // stored passwords survive rst_n, like the media copy
  password_store u_store
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .port    (pwBus)
  );

  // hard reset clears the mismatch count and expiry
  attempt_counter u_attempts
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .inc     (cntInc),
    .clr     (hardRst),
    .expired (expired)
  );

  assign take    = ctl_r == security_lock_pkg::CT_IDLE && cmdValid
                   && ready_r && !hardRst;
  assign pwMatch = pwBus.rdData == pw_r;

  // command decode and security state next values
  always_comb
  begin
    ok            = 1'b0;
    ctl_nxt       = ctl_r;
    sec_nxt       = sec_r;
    op_nxt        = op_r;
    media_nxt     = media_r;
    useMaster_nxt = useMaster_r;
    cmdLvl_nxt    = cmdLvl_r;
    rev_nxt       = rev_r;
    pw_nxt        = pw_r;
    done_nxt      = 1'b0;
    abort_nxt     = 1'b0;
    erase_nxt     = 1'b0;
    lockEn_nxt    = lockEn_r;
    lvlMax_nxt    = lvlMax_r;
    prepared_nxt  = prepared_r;
    mrev_nxt      = mrev_r;
    cntInc        = 1'b0;
    pwBus.rdEn    = 1'b0;
    pwBus.rdAddr  = cmdUseMaster;
    pwBus.wrEn    = 1'b0;
    pwBus.wrAddr  = useMaster_r;
    pwBus.wrData  = pw_r;
    case (ctl_r)
      security_lock_pkg::CT_INIT:
      begin
        // R3 no user password: come up unlocked
        // R11 user password set: come up locked
        sec_nxt    = nvUserPwdSet ? security_lock_pkg::SEC_LOCKED
                                  : security_lock_pkg::SEC_UNLOCKED;
        lockEn_nxt = nvUserPwdSet;
        lvlMax_nxt = nvLevelMax;
        // R10 revision code kept across power cycles
        mrev_nxt   = nvMasterRev;
        ctl_nxt    = security_lock_pkg::CT_IDLE;
      end
      security_lock_pkg::CT_IDLE:
      begin
        if (take)
        begin
          op_nxt        = cmdOpcode;
          media_nxt     = cmdIsMedia;
          useMaster_nxt = cmdUseMaster;
          cmdLvl_nxt    = cmdLevelMax;
          rev_nxt       = cmdRevCode;
          pw_nxt        = cmdPassword;
          pwBus.rdEn    = 1'b1;
          ctl_nxt       = security_lock_pkg::CT_EXEC;
        end
      end
      security_lock_pkg::CT_EXEC:
      begin
        ctl_nxt      = security_lock_pkg::CT_IDLE;
        // erase unit must directly follow erase prepare
        prepared_nxt = 1'b0;
        // R1 opcode decode
        case (op_r)
          security_lock_pkg::OP_SET_PW:
          begin
            // R4 password change only while unlocked
            ok = sec_r == security_lock_pkg::SEC_UNLOCKED;
            pwBus.wrEn = ok;
            if (ok && useMaster_r)
            begin
              // R8 master entry leaves the lock function alone
              // R9 out-of-range codes leave the old code in place
              if (rev_r >= security_lock_pkg::REV_MIN
                  && rev_r <= security_lock_pkg::REV_MAX)
              begin
                mrev_nxt = rev_r;
              end
            end
            else if (ok)
            begin
              // R11 user password arms the lock
              lockEn_nxt = 1'b1;
              lvlMax_nxt = cmdLvl_r;
            end
          end
          security_lock_pkg::OP_UNLOCK:
          begin
            // R13 expired or frozen: refused outright
            // R6 master accepted at high level
            // R7 master at maximum level refused here
            ok = sec_r != security_lock_pkg::SEC_FROZEN && !expired
                 && !(useMaster_r && lvlMax_r) && pwMatch;
            // R15 a mismatch is counted, state stays
            cntInc = sec_r != security_lock_pkg::SEC_FROZEN
                     && !expired && !(useMaster_r && lvlMax_r)
                     && !pwMatch;
            if (ok)
            begin
              sec_nxt = security_lock_pkg::SEC_UNLOCKED;
            end
          end
          security_lock_pkg::OP_ERASE_PREP:
          begin
            ok           = sec_r != security_lock_pkg::SEC_FROZEN;
            prepared_nxt = ok;
          end
          security_lock_pkg::OP_ERASE_UNIT:
          begin
            // R7 master unlock at maximum level erases data
            ok = sec_r != security_lock_pkg::SEC_FROZEN && !expired
                 && prepared_r && pwMatch;
            cntInc = sec_r != security_lock_pkg::SEC_FROZEN
                     && !expired && prepared_r && !pwMatch;
            if (ok)
            begin
              sec_nxt    = security_lock_pkg::SEC_UNLOCKED;
              lockEn_nxt = 1'b0;
              erase_nxt  = 1'b1;
            end
          end
          security_lock_pkg::OP_FREEZE:
          begin
            // R4 freeze from unlocked (or again when frozen)
            ok = sec_r != security_lock_pkg::SEC_LOCKED;
            if (ok)
            begin
              sec_nxt = security_lock_pkg::SEC_FROZEN;
            end
          end
          security_lock_pkg::OP_DISABLE_PW:
          begin
            ok = sec_r == security_lock_pkg::SEC_UNLOCKED && pwMatch;
            if (ok)
            begin
              lockEn_nxt = 1'b0;
            end
          end
          default:
          begin
            // R2 media access refused while locked
            // R14 everything else executes
            ok = !(media_r && sec_r == security_lock_pkg::SEC_LOCKED);
          end
        endcase
        done_nxt  = ok;
        abort_nxt = !ok;
      end
      default:
      begin
        ctl_nxt = security_lock_pkg::CT_IDLE;
      end
    endcase
    // R5 hard reset relocks when the lock is enabled but never leaves frozen
    // R11 hard reset applies the lock function
    if (hardRst && ctl_r != security_lock_pkg::CT_INIT)
    begin
      ctl_nxt      = security_lock_pkg::CT_IDLE;
      done_nxt     = 1'b0;
      abort_nxt    = 1'b0;
      erase_nxt    = 1'b0;
      pwBus.wrEn   = 1'b0;
      prepared_nxt = 1'b0;
      // a dropped command leaves no trace in count, lock or level
      cntInc       = 1'b0;
      lockEn_nxt   = lockEn_r;
      lvlMax_nxt   = lvlMax_r;
      mrev_nxt     = mrev_r;
      if (sec_r != security_lock_pkg::SEC_FROZEN)
      begin
        sec_nxt = lockEn_r ? security_lock_pkg::SEC_LOCKED
                           : security_lock_pkg::SEC_UNLOCKED;
      end
    end
    ready_nxt = ctl_nxt == security_lock_pkg::CT_IDLE;
  end

  // state registers; only power-on reset reaches them
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r       <= security_lock_pkg::CT_RESET;
      sec_r       <= security_lock_pkg::SEC_RESET;
      op_r        <= 8'h00;
      media_r     <= 1'b0;
      useMaster_r <= 1'b0;
      cmdLvl_r    <= 1'b0;
      rev_r       <= 16'h0000;
      pw_r        <= '0;
      ready_r     <= 1'b0;
      done_r      <= 1'b0;
      abort_r     <= 1'b0;
      erase_r     <= 1'b0;
      lockEn_r    <= 1'b0;
      lvlMax_r    <= 1'b0;
      prepared_r  <= 1'b0;
      mrev_r      <= security_lock_pkg::REV_SHIP;
    end
    else
    begin
      ctl_r       <= ctl_nxt;
      sec_r       <= sec_nxt;
      op_r        <= op_nxt;
      media_r     <= media_nxt;
      useMaster_r <= useMaster_nxt;
      cmdLvl_r    <= cmdLvl_nxt;
      rev_r       <= rev_nxt;
      pw_r        <= pw_nxt;
      ready_r     <= ready_nxt;
      done_r      <= done_nxt;
      abort_r     <= abort_nxt;
      erase_r     <= erase_nxt;
      lockEn_r    <= lockEn_nxt;
      lvlMax_r    <= lvlMax_nxt;
      prepared_r  <= prepared_nxt;
      mrev_r      <= mrev_nxt;
    end
  end

  // outputs straight from flops
  assign cmdReady                = ready_r;
  assign rspDone                 = done_r;
  assign rspAbort                = abort_r;
  assign eraseStart              = erase_r;
  assign secLocked               = sec_r[0];
  assign secUnlocked             = sec_r[1];
  assign secFrozen               = sec_r[2];
  assign lockEnabled             = lockEn_r;
  assign levelMax                = lvlMax_r;
  assign attemptLimitExpiredFlag = expired;
  assign masterRevCode           = mrev_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic execNow;
  assign execNow = ctl_r == security_lock_pkg::CT_EXEC && !hardRst;

  freeze_cmd_a: assert property ( // R1
    execNow && op_r == security_lock_pkg::OP_FREEZE && !secLocked
    |=> secFrozen && rspDone) else $error("freeze did not freeze");
  locked_media_a: assert property ( // R2
    execNow && secLocked && media_r && op_r[7:4] != 4'hf
    |=> rspAbort && secLocked) else $error("media access not refused");
  unlock_ok_a: assert property ( // R3
    execNow && op_r == security_lock_pkg::OP_UNLOCK && !secFrozen
    && !expired && !useMaster_r && pwMatch
    |=> secUnlocked && rspDone) else $error("good unlock refused");
  frozen_pw_a: assert property ( // R4
    execNow && secFrozen && (op_r == security_lock_pkg::OP_SET_PW
    || op_r == security_lock_pkg::OP_DISABLE_PW)
    |=> rspAbort && $stable(lockEnabled)) else $error("frozen change");
  frozen_stays_a: assert property ( // R5
    secFrozen |=> secFrozen) else $error("left frozen state");
  master_high_a: assert property ( // R6
    execNow && op_r == security_lock_pkg::OP_UNLOCK && secLocked
    && useMaster_r && !lvlMax_r && !expired && pwMatch
    |=> secUnlocked) else $error("master unlock refused at high");
  master_max_a: assert property ( // R7
    execNow && op_r == security_lock_pkg::OP_UNLOCK && useMaster_r
    && lvlMax_r |=> rspAbort && $stable(sec_r))
    else $error("master unlock allowed at maximum");
  master_nolock_a: assert property ( // R8
    execNow && op_r == security_lock_pkg::OP_SET_PW && useMaster_r
    |=> $stable(lockEnabled)) else $error("master set changed lock");
  rev_range_a: assert property ( // R9
    execNow && op_r == security_lock_pkg::OP_SET_PW && useMaster_r
    && (rev_r == 16'h0000 || rev_r == 16'hffff)
    |=> $stable(masterRevCode)) else $error("bad revision accepted");
  lock_reset_a: assert property ( // R11
    hardRst && ctl_r != security_lock_pkg::CT_INIT && lockEnabled
    && !secFrozen |=> secLocked) else $error("hard reset did not lock");
  expired_abort_a: assert property ( // R13
    execNow && op_r == security_lock_pkg::OP_UNLOCK && expired
    |=> rspAbort ##1 !rspDone) else $error("unlock after expiry");
  mismatch_a: assert property ( // R15
    execNow && op_r == security_lock_pkg::OP_UNLOCK && !pwMatch
    |=> rspAbort && $stable(sec_r)) else $error("mismatch not aborted");
endmodule // drive_security_lock_fsm
`default_nettype wire

// ===== test/host_cmd_model.sv
// host-side model that issues commands to the lock state machine
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model
(
  input  wire logic         clk_sys,
  input  wire logic         cmdReady,
  input  wire logic         rspDone,
  input  wire logic         rspAbort,
  input  wire logic         eraseStart,
  output var  logic         cmdValid,
  output var  logic [7:0]   cmdOpcode,
  output var  logic         cmdIsMedia,
  output var  logic         cmdUseMaster,
  output var  logic         cmdLevelMax,
  output var  logic [15:0]  cmdRevCode,
  output var  logic [255:0] cmdPassword,
  output var  logic         hang
);
  // quiet bus at time zero
  initial
  begin
    cmdValid = 1'b0;
    cmdOpcode = 8'h00;
    cmdIsMedia = 1'b0;
    cmdUseMaster = 1'b0;
    cmdLevelMax = 1'b0;
    cmdRevCode = 16'h0000;
    cmdPassword = '0;
    hang = 1'b0;
  end

  // opcode and operands held until the taking edge
  task automatic issue(input logic [7:0] op, input logic [255:0] pw,
                       input logic um, input logic lm,
                       input logic [15:0] rv, input logic md,
                       output logic [2:0] rsp);
    int n;
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmdOpcode <= op;
    cmdPassword <= pw;
    cmdUseMaster <= um;
    cmdLevelMax <= lm;
    cmdRevCode <= rv;
    cmdIsMedia <= md;
    // ready read before this edge's updates land, as the device sees it
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_sys);
      if (cmdReady)
        break;
    end
    hang <= (n == 20);
    // released opcode, password and revision code turn to junk so a late sample cannot pass
    cmdValid <= 1'b0;
    cmdOpcode <= ~op;
    cmdPassword <= ~pw;
    cmdRevCode <= ~rv;
    @(posedge clk_sys);
    #1;
    rsp = {rspDone, rspAbort, eraseStart};
  endtask
endmodule // host_cmd_model
`default_nettype wire

// ===== test/drive_security_lock_fsm_tb.sv
// self-checking bench for the drive security lock state machine
`timescale 1ns/1ps
`default_nettype none
module drive_security_lock_fsm_tb;
  localparam logic [7:0]   SETP = security_lock_pkg::OP_SET_PW;
  localparam logic [7:0]   UNLK = security_lock_pkg::OP_UNLOCK;
  localparam logic [7:0]   PREP = security_lock_pkg::OP_ERASE_PREP;
  localparam logic [7:0]   ERAS = security_lock_pkg::OP_ERASE_UNIT;
  localparam logic [7:0]   FRZ  = security_lock_pkg::OP_FREEZE;
  localparam logic [7:0]   DISP = security_lock_pkg::OP_DISABLE_PW;
  localparam logic [7:0]   OTH  = 8'h20;
  localparam logic [255:0] PW_U = 256'h1111;
  localparam logic [255:0] PW_M = 256'h2222;
  localparam logic [255:0] PW_X = 256'h3333;
  localparam logic [2:0]   LK = 3'h4, UL = 3'h2, FZ = 3'h1;
  localparam logic [2:0]   DN = 3'h4, AB = 3'h2, ER = 3'h5;

  logic clk_sys, rst_n, hardRst, cmdValid, cmdIsMedia, cmdUseMaster;
  logic cmdLevelMax, cmdReady, rspDone, rspAbort, eraseStart, hang;
  logic secLocked, secUnlocked, secFrozen, lockEnabled, levelMax, expd;
  logic nvUser, nvMax;
  logic [7:0]   cmdOpcode;
  logic [15:0]  cmdRevCode, masterRevCode, nvRev;
  logic [255:0] cmdPassword;
  int           nMismatch = 0;
  int           checks = 0;

  drive_security_lock_fsm dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .hardRst(hardRst), .nvUserPwdSet(nvUser), .nvLevelMax(nvMax),
    .nvMasterRev(nvRev), .cmdValid(cmdValid), .cmdOpcode(cmdOpcode),
    .cmdIsMedia(cmdIsMedia), .cmdUseMaster(cmdUseMaster),
    .cmdLevelMax(cmdLevelMax), .cmdRevCode(cmdRevCode),
    .cmdPassword(cmdPassword), .cmdReady(cmdReady), .rspDone(rspDone),
    .rspAbort(rspAbort), .eraseStart(eraseStart), .secLocked(secLocked),
    .secUnlocked(secUnlocked), .secFrozen(secFrozen),
    .lockEnabled(lockEnabled), .levelMax(levelMax),
    .attemptLimitExpiredFlag(expd), .masterRevCode(masterRevCode));

  host_cmd_model host (.clk_sys(clk_sys), .cmdReady(cmdReady),
    .rspDone(rspDone), .rspAbort(rspAbort), .eraseStart(eraseStart),
    .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdIsMedia(cmdIsMedia),
    .cmdUseMaster(cmdUseMaster), .cmdLevelMax(cmdLevelMax),
    .cmdRevCode(cmdRevCode), .cmdPassword(cmdPassword), .hang(hang));

  // 200 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic st(input logic [2:0] exp);
    check("state", {13'h0000, secLocked, secUnlocked, secFrozen},
          {13'h0000, exp});
  endtask

  // one command through the host model, response judged here
  task automatic run(input logic [7:0] op, input logic [255:0] pw,
                     input logic [2:0] exp, input logic um = 1'b0,
                     input logic lm = 1'b0, input logic [15:0] rv = 16'h0001,
                     input logic md = 1'b0);
    logic [2:0] rsp;
    host.issue(op, pw, um, lm, rv, md, rsp);
    if (hang)
    begin
      nMismatch++;
      wrapUp();
    end
    check("response", {13'h0000, rsp}, {13'h0000, exp});
  endtask

  // one-cycle hard reset, settled state sampled after it acts
  task automatic hard();
    @(posedge clk_sys);
    hardRst <= 1'b1;
    @(posedge clk_sys);
    hardRst <= 1'b0;
    #1;
  endtask

  task automatic t_setup();
    run(SETP, PW_M, DN, 1'b1, 1'b0, 16'h0005);
    check("lock", {15'h0000, lockEnabled}, 16'h0000);
    check("rev", masterRevCode, 16'h0005);
    run(SETP, PW_M, DN, 1'b1, 1'b0, 16'hffff);
    check("rev", masterRevCode, 16'h0005);
    run(SETP, PW_U, DN);
    check("lock", {15'h0000, lockEnabled}, 16'h0001);
    st(UL);
    hard();
    st(LK);
    run(OTH, PW_X, AB, 1'b0, 1'b0, 16'h0001, 1'b1);
    run(OTH, PW_X, DN);
    run(UNLK, PW_M, DN, 1'b1);
    st(UL);
    $display("test setup done");
  endtask

  task automatic t_limit();
    hard();
    repeat (4) run(UNLK, PW_X, AB);
    st(LK);
    check("expired", {15'h0000, expd}, 16'h0000);
    run(UNLK, PW_X, AB, 1'b1);
    check("expired", {15'h0000, expd}, 16'h0001);
    run(UNLK, PW_U, AB);
    hard();
    check("expired", {15'h0000, expd}, 16'h0000);
    run(UNLK, PW_U, DN);
    st(UL);
    $display("test limit done");
  endtask

  task automatic t_max();
    run(SETP, PW_U, DN, 1'b0, 1'b1);
    hard();
    check("level", {15'h0000, levelMax}, 16'h0001);
    run(UNLK, PW_M, AB, 1'b1);
    st(LK);
    run(PREP, PW_M, DN, 1'b1);
    run(ERAS, PW_M, ER, 1'b1);
    st(UL);
    $display("test max done");
  endtask

  task automatic t_freeze();
    run(SETP, PW_U, DN);
    run(DISP, PW_U, DN);
    check("lock", {15'h0000, lockEnabled}, 16'h0000);
    run(SETP, PW_U, DN);
    run(FRZ, PW_X, DN);
    st(FZ);
    run(SETP, PW_U, AB);
    run(DISP, PW_U, AB);
    run(UNLK, PW_U, AB);
    hard();
    st(FZ);
    run(OTH, PW_X, DN, 1'b0, 1'b0, 16'h0001, 1'b1);
    $display("test freeze done");
  endtask

  // power cycle with straps of a drive holding a user password
  task automatic t_power();
    @(posedge clk_sys);
    nvUser <= 1'b1;
    nvMax <= 1'b1;
    nvRev <= 16'h0005;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    st(LK);
    check("level", {15'h0000, levelMax}, 16'h0001);
    check("rev", masterRevCode, 16'h0005);
    run(OTH, PW_X, AB, 1'b0, 1'b0, 16'h0001, 1'b1);
    run(UNLK, PW_U, DN);
    $display("test power done");
  endtask

  // reset for six cycles, then the scenarios in order
  initial
  begin
    rst_n = 1'b0;
    hardRst = 1'b0;
    nvUser = 1'b0;
    nvMax = 1'b0;
    nvRev = 16'hfffe;
    repeat (5) @(posedge clk_sys);
    #1;
    check("rev", masterRevCode, 16'hfffe);
    st(UL);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    check("lock", {15'h0000, lockEnabled}, 16'h0000);
    t_setup();
    t_limit();
    t_max();
    t_freeze();
    t_power();
    wrapUp();
  end
endmodule // drive_security_lock_fsm_tb
`default_nettype wire
